// ---- rtl/bsc_tap_fsm.sv ----
// Purpose: sixteen-state test port controller
// Assumes: step is a one-cycle pulse at each rising test clock
// Notes: power-on reset forces the reset state
`timescale 1ns/10ps
module bsc_tap_fsm (
	input wire logic clk,
	input wire logic srst,
	input wire logic step,
	input wire logic mode_sel,
	output bsc_pkg::bsc_tap_state_t state
);
	import bsc_pkg::*;

	bsc_tap_state_t next_state; // successor on the next step

	// ****************************************
	// next state
	// ****************************************
	// standard transition table, mode select picks the branch [R12]
	always_comb begin
		next_state = state;
		unique case (state)
			ST_RESET: next_state = mode_sel ? ST_RESET : ST_IDLE;
			ST_IDLE: next_state = mode_sel ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: next_state = mode_sel ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: next_state = mode_sel ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: next_state = mode_sel ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: next_state = mode_sel ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: next_state = mode_sel ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: next_state = mode_sel ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: next_state = mode_sel ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: next_state = mode_sel ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: next_state = mode_sel ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: next_state = mode_sel ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: next_state = mode_sel ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: next_state = mode_sel ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: next_state = mode_sel ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: next_state = mode_sel ? ST_SEL_DR : ST_IDLE;
			default: next_state = ST_RESET; // illegal code recovers
		endcase
	end

	// ****************************************
	// state register
	// ****************************************
	// internal reset wins regardless of the tester [R11]
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= ST_RESET; // [R11]
		end else if (step) begin
			state <= next_state; // [R12]
		end
	end
endmodule

// ---- rtl/bsc_top.sv ----
// Purpose: boundary scan chain behind a four-wire test port
// Assumes: test clock far slower than clk, sampled as a plain input
// Notes: chain shifts toward test data out, cell 0 leaves first
//
// Overview of operation
// R1 - port A clock, frame each set two cells
// R2 - port B clock, frame each set one cell
// R3 - loaded output reads back also two lower
// R4 - serial io drive enable never unloaded
// R5 - serial inputs resampled when readback starts
// R6 - unload order from enable through clocks
// R7 - load order cell 0 to 44
// R8 - five-bit instruction decode, others reserved
// R9 - bypass is one single stage
// R10 - 32-bit fixed identification register
// R11 - power-on reset forces controller reset state
// R12 - standard controller, tdo on falling clock
`timescale 1ns/10ps
`include "bsc_defines.svh"
module bsc_top #(
	parameter logic [31:0] IDCODE_VALUE = 32'h10000001, // arbitrary value
	parameter int CHAIN_LEN = `BSC_CHAIN_LEN
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	output logic tdo,
	output logic tdo_oe_n,
	input wire logic [15:0] port_a_data,
	input wire logic [15:0] port_b_data,
	input wire logic port_a_data_clock_in,
	input wire logic port_b_data_clock_in,
	input wire logic port_a_frame_in,
	input wire logic port_b_frame_in,
	input wire logic reset_pin,
	input wire logic chip_select_n,
	input wire logic sclk,
	input wire logic sdio_in,
	output logic sdio_out,
	output logic sdio_oe_n,
	output logic sdo,
	output logic sdo_oe_n,
	output logic irq_n,
	output logic pll_lock,
	input wire logic core_sdio_out,
	input wire logic core_sdio_oe_n,
	input wire logic core_sdo,
	input wire logic core_sdo_oe_n,
	input wire logic core_irq_n,
	input wire logic core_pll_lock
);
	import bsc_pkg::*;

	// ****************************************
	// elaboration checks
	// ****************************************
	// cell positions are fixed, so the length cannot change
	if (CHAIN_LEN != `BSC_CHAIN_LEN) begin : g_bad_len
		$error("chain length must be 45");
	end
	if (IDCODE_VALUE[0] != 1'b1) begin : g_bad_id
		$error("identification code must end in one");
	end

	// ****************************************
	// input synchronisers
	// ****************************************
	localparam int PINS = 40; // pin inputs passing two flops
	logic [2:0] tap_s1; // first stage, read only by second
	logic [2:0] tap_s2; // tck, tms, tdi settled
	logic tck_d; // previous settled test clock
	logic [PINS-1:0] pin_s1; // first stage of pin inputs
	logic [PINS-1:0] pin_s2; // settled pin inputs
	logic tck_rise; // one-cycle pulse per rising test clock
	logic tck_fall; // one-cycle pulse per falling test clock

	// two flops on every test port and pin input before use; core drives go straight to the pin registers
	always_ff @(posedge clk) begin
		tap_s1 <= {tck, tms, tdi};
		tap_s2 <= tap_s1;
		pin_s1 <= {port_a_data, port_b_data, port_a_data_clock_in,
			port_b_data_clock_in, port_a_frame_in, port_b_frame_in,
			reset_pin, chip_select_n, sclk, sdio_in};
		pin_s2 <= pin_s1;
	end

	// edge finder on the settled test clock
	always_ff @(posedge clk) begin
		if (srst) begin
			tck_d <= 1'b0;
		end else begin
			tck_d <= tap_s2[2];
		end
	end

	assign tck_rise = tap_s2[2] & ~tck_d;
	assign tck_fall = ~tap_s2[2] & tck_d;

	// named views of the settled pins
	logic [15:0] pa; // port A data bits
	logic [15:0] pb; // port B data bits
	logic dca, dcb, fra, frb; // port clocks and frames
	logic rst_p, csn_p, sclk_p, sdio_p; // serial port inputs
	assign {pa, pb, dca, dcb, fra, frb} = pin_s2[PINS-1:4];
	assign {rst_p, csn_p, sclk_p, sdio_p} = pin_s2[3:0];

	// ****************************************
	// controller
	// ****************************************
	bsc_tap_state_t state; // current controller state

	bsc_tap_fsm u_fsm (
		.clk(clk),
		.srst(srst),
		.step(tck_rise),
		.mode_sel(tap_s2[1]),
		.state(state)
	);

	// ****************************************
	// instruction register
	// ****************************************
	logic [`BSC_IR_WIDTH-1:0] ir_shift; // instruction shift stage
	logic [`BSC_IR_WIDTH-1:0] ir; // active instruction

	// capture, shift and update of the instruction
	always_ff @(posedge clk) begin
		if (srst || (tck_rise && state == ST_RESET)) begin
			ir_shift <= `BSC_IR_CAPTURE;
			ir <= `BSC_IR_IDCODE;
		end else if (tck_rise) begin
			unique case (state)
				ST_CAP_IR: ir_shift <= `BSC_IR_CAPTURE;
				ST_SH_IR: ir_shift <= {tap_s2[0],
					ir_shift[`BSC_IR_WIDTH-1:1]};
				ST_UPD_IR: ir <= ir_shift;
				default: ir_shift <= ir_shift; // other states hold
			endcase
		end
	end

	// decode; reserved codes fall to bypass
	logic sel_bsr, sel_id, is_extest; // register selection
	always_comb begin
		sel_bsr = 1'b0;
		sel_id = 1'b0;
		is_extest = 1'b0;
		unique case (ir) // [R8]
			`BSC_IR_EXTEST: begin
				sel_bsr = 1'b1;
				is_extest = 1'b1;
			end
			`BSC_IR_SAMPLE: sel_bsr = 1'b1;
			`BSC_IR_IDCODE: sel_id = 1'b1;
			default: sel_bsr = 1'b0; // bypass and reserved
		endcase
	end

	// ****************************************
	// capture view of the chain
	// ****************************************
	logic [CHAIN_LEN-1:0] upd; // update latch, load order [R7]
	logic sdio_pre; // serial data kept from the preload sample
	logic [CHAIN_LEN-1:0] cap; // unload-order capture word

	// drive-enable cell has no capture slot at all [R4]
	always_comb begin
		cap = '0;
		cap[`BSC_UL_SDO_EN] = ~sdo_oe_n; // [R6]
		cap[`BSC_UL_SDO] = sdo;
		cap[`BSC_UL_LOCK] = pll_lock;
		cap[`BSC_UL_IRQ] = irq_n;
		cap[`BSC_UL_SDIO_PRE] = sdio_pre;
		// live pins, read fresh at capture time [R5]
		cap[`BSC_UL_SDIO] = sdio_p;
		cap[`BSC_UL_SCLK] = sclk_p;
		cap[`BSC_UL_CSN] = csn_p;
		cap[`BSC_UL_RESET] = rst_p;
		for (int i = 0; i < 16; i++) begin
			cap[`BSC_UL_PORT_B + i] = pb[15-i]; // [R6]
			cap[`BSC_UL_PORT_A + i] = pa[15-i];
		end
		// port A pins land in the shared and own cells [R1]
		cap[`BSC_UL_FRAME_B] = frb | fra; // [R2]
		cap[`BSC_UL_DCLK_B] = dcb | dca; // [R2]
		cap[`BSC_UL_FRAME_A] = fra; // [R1]
		cap[`BSC_UL_DCLK_A] = dca; // [R1]
		// own cell already holds the driven pin; the echo lands two lower
		// in load numbering, so exactly two cells read set [R3]
		if (is_extest) begin
			cap[`BSC_LD_SDO - `BSC_LOOPBACK_DIST] |= upd[`BSC_LD_SDO];
			cap[`BSC_LD_LOCK - `BSC_LOOPBACK_DIST] |= upd[`BSC_LD_LOCK];
			cap[`BSC_LD_IRQ - `BSC_LOOPBACK_DIST] |= upd[`BSC_LD_IRQ];
		end
	end

	// ****************************************
	// data registers
	// ****************************************
	logic [CHAIN_LEN-1:0] bsr; // boundary shift stage
	logic [31:0] id_sr; // identification shift stage
	logic byp; // single bypass stage

	// capture, shift and update of the selected register
	always_ff @(posedge clk) begin
		if (srst) begin
			bsr <= '0;
			upd <= '0;
			id_sr <= '0;
			byp <= 1'b0;
			sdio_pre <= 1'b0;
		end else if (tck_rise) begin
			unique case (state)
				ST_CAP_DR: begin
					if (sel_bsr) begin
						bsr <= cap; // [R5]
					end
					if (sel_bsr && !is_extest) begin
						sdio_pre <= sdio_p; // kept for next unload
					end
					id_sr <= IDCODE_VALUE; // [R10]
					byp <= 1'b0;
				end
				ST_SH_DR: begin
					if (sel_bsr) begin
						bsr <= {tap_s2[0], bsr[CHAIN_LEN-1:1]}; // [R7]
					end else if (sel_id) begin
						id_sr <= {tap_s2[0], id_sr[31:1]}; // [R10]
					end else begin
						byp <= tap_s2[0]; // [R9]
					end
				end
				ST_UPD_DR: begin
					if (sel_bsr) begin
						upd <= bsr; // [R7]
					end
				end
				default: byp <= byp; // other states hold
			endcase
		end
	end

	// ****************************************
	// test data out
	// ****************************************
	logic shifting; // controller in either shift state
	logic tdo_bit; // lowest bit of the active path
	assign shifting = (state == ST_SH_DR) || (state == ST_SH_IR);
	assign tdo_bit = (state == ST_SH_IR) ? ir_shift[0] :
		sel_bsr ? bsr[0] : sel_id ? id_sr[0] : byp;

	// output moves only on the falling test clock [R12]
	always_ff @(posedge clk) begin
		if (srst) begin
			tdo <= 1'b0;
			tdo_oe_n <= 1'b1;
		end else if (tck_fall) begin
			tdo <= tdo_bit; // [R12]
			tdo_oe_n <= ~shifting;
		end
	end

	// ****************************************
	// pin drive
	// ****************************************
	// external test hands the pins to the update latch
	always_ff @(posedge clk) begin
		if (srst) begin
			sdio_out <= 1'b0;
			sdio_oe_n <= 1'b1;
			sdo <= 1'b0;
			sdo_oe_n <= 1'b1;
			irq_n <= 1'b1;
			pll_lock <= 1'b0;
		end else if (is_extest) begin
			sdio_out <= upd[`BSC_LD_SDIO];
			sdio_oe_n <= ~upd[`BSC_LD_SDIO_DRV]; // [R4]
			sdo <= upd[`BSC_LD_SDO]; // [R3]
			sdo_oe_n <= ~upd[`BSC_LD_SDO_EN];
			irq_n <= upd[`BSC_LD_IRQ];
			pll_lock <= upd[`BSC_LD_LOCK];
		end else begin
			sdio_out <= core_sdio_out;
			sdio_oe_n <= core_sdio_oe_n;
			sdo <= core_sdo;
			sdo_oe_n <= core_sdo_oe_n;
			irq_n <= core_irq_n;
			pll_lock <= core_pll_lock;
		end
	end
endmodule

// ---- shared/bsc_defines.svh ----
// Purpose: constants for the boundary scan test port
// Assumes: included by bare name
// Notes: positions count from the cell nearest test data out
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// ****************************************
// instruction codes
// ****************************************
`define BSC_IR_WIDTH 5
`define BSC_IR_EXTEST 5'h00
`define BSC_IR_IDCODE 5'h01
`define BSC_IR_SAMPLE 5'h02
`define BSC_IR_BYPASS 5'h1f
`define BSC_IR_CAPTURE 5'h01

// ****************************************
// chain geometry, load order
// ****************************************
`define BSC_CHAIN_LEN 45
`define BSC_LD_SDIO_DRV 0
`define BSC_LD_SDO_EN 1
`define BSC_LD_SDO 2
`define BSC_LD_LOCK 3
`define BSC_LD_IRQ 4
`define BSC_LD_SDIO 5

// ****************************************
// chain geometry, unload order
// ****************************************
`define BSC_UL_SDO_EN 0
`define BSC_UL_SDO 1
`define BSC_UL_LOCK 2
`define BSC_UL_IRQ 3
`define BSC_UL_SDIO_PRE 4
`define BSC_UL_SDIO 5
`define BSC_UL_SCLK 6
`define BSC_UL_CSN 7
`define BSC_UL_RESET 8
`define BSC_UL_PORT_B 9
`define BSC_UL_PORT_A 25
`define BSC_UL_FRAME_B 41
`define BSC_UL_DCLK_B 42
`define BSC_UL_FRAME_A 43
`define BSC_UL_DCLK_A 44
`define BSC_LOOPBACK_DIST 2

`endif

// ---- shared/bsc_pkg.sv ----
// Purpose: types for the boundary scan test port
// Assumes: nothing
// Notes: one-hot controller states
package bsc_pkg;
	// ****************************************
	// controller states, one-hot
	// ****************************************
	typedef enum logic [15:0] {
		ST_RESET = 16'h0001,
		ST_IDLE = 16'h0002,
		ST_SEL_DR = 16'h0004,
		ST_CAP_DR = 16'h0008,
		ST_SH_DR = 16'h0010,
		ST_EX1_DR = 16'h0020,
		ST_PAU_DR = 16'h0040,
		ST_EX2_DR = 16'h0080,
		ST_UPD_DR = 16'h0100,
		ST_SEL_IR = 16'h0200,
		ST_CAP_IR = 16'h0400,
		ST_SH_IR = 16'h0800,
		ST_EX1_IR = 16'h1000,
		ST_PAU_IR = 16'h2000,
		ST_EX2_IR = 16'h4000,
		ST_UPD_IR = 16'h8000
	} bsc_tap_state_t;
endpackage

// ---- sim/bsc_jtag_tester.sv ----
// Purpose: behavioural scan tester on the test port
// Assumes: tck period 8 clk, 800 ns
// Notes: tck rests low between frames
`timescale 1ns/10ps
module bsc_jtag_tester (
	input wire logic clk,
	input wire logic tdo,
	output logic tck,
	output logic tms,
	output logic tdi
);
	// ****
	// one test clock period
	// ****
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// mode and data set while tck low, tdo taken before the rise
	task automatic step(input logic md, input logic d, output logic q);
		tms = md;
		tdi = d;
		repeat (4) @(negedge clk);
		q = tdo;
		tck = 1'b1;
		repeat (4) @(negedge clk);
		tck = 1'b0;
	endtask
	// five ones reach reset from anywhere, then idle
	task automatic tap_reset();
		logic q;
		repeat (5) step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
	// idle to shift, n bits lsb first, back to idle
	task automatic scan(input bit ir, input int n, input logic [63:0] din,
		output logic [63:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b0, q);
		if (ir) begin
			step(1'b1, 1'b0, q);
		end
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, ~tdi, q);
		step(1'b0, ~tdi, q);
	endtask
endmodule

// ---- sim/bsc_top_checker.sv ----
// Purpose: port checks of the scan port
// Assumes: tck half period of 4 clk
// Notes: pin moves traced back to tck edges
`timescale 1ns/10ps
module bsc_top_checker (
	input wire logic clk,
	input wire logic srst,
	input wire logic tck,
	input wire logic tdo,
	input wire logic tdo_oe_n,
	input wire logic sdo,
	input wire logic sdo_oe_n,
	input wire logic sdio_oe_n,
	input wire logic sdio_out,
	input wire logic irq_n,
	input wire logic pll_lock,
	input wire logic core_irq_n,
	input wire logic core_sdo_oe_n,
	input wire logic core_pll_lock
);
	// ****
	// properties
	// ****
	default clocking @(posedge clk); endclocking
	// reset quiets the port, not disabled by itself
	property p_rst_port;
		srst |=> !tdo && tdo_oe_n;
	endproperty
	a_rst_port: assert property (p_rst_port)
		else $error("port not idle in reset");
	property p_rst_pins;
		srst |=> sdo_oe_n && sdio_oe_n && irq_n && !sdo && !pll_lock && !sdio_out;
	endproperty
	a_rst_pins: assert property (p_rst_pins)
		else $error("pins not idle in reset");
	// after release the instruction is not a pin test
	property p_core;
		disable iff (srst) $fell(srst) |=> pll_lock == $past(core_pll_lock) && irq_n == $past(core_irq_n);
	endproperty
	a_core: assert property (p_core)
		else $error("pins not from core after reset");
	// tdo may only move a few clk after tck fell
	property p_tdo_fall;
		disable iff (srst) $changed(tdo) |-> !$past(tck, 3) && $past(tck, 7);
	endproperty
	a_tdo_fall: assert property (p_tdo_fall)
		else $error("tdo moved off falling tck");
	property p_oe_fall;
		disable iff (srst) $changed(tdo_oe_n) |-> !$past(tck, 3) && $past(tck, 7);
	endproperty
	a_oe_fall: assert property (p_oe_fall)
		else $error("tdo enable moved off falling tck");
	// a pin off its core value was set at a rising tck
	property p_irq_src;
		disable iff (srst) $changed(irq_n) && irq_n != $past(core_irq_n) |-> $past(tck, 3);
	endproperty
	a_irq_src: assert property (p_irq_src)
		else $error("irq pin moved without update");
	property p_sdo_src;
		disable iff (srst) $changed(sdo_oe_n) && sdo_oe_n != $past(core_sdo_oe_n) |-> $past(tck, 3);
	endproperty
	a_sdo_src: assert property (p_sdo_src)
		else $error("sdo enable moved without update");
	property p_lock_src;
		disable iff (srst) $changed(pll_lock) && pll_lock != $past(core_pll_lock) |-> $past(tck, 3);
	endproperty
	a_lock_src: assert property (p_lock_src)
		else $error("lock pin moved without update");
	// main scenarios reached
	c_shift: cover property (disable iff (srst) $fell(tdo_oe_n));
	c_ext: cover property (disable iff (srst) pll_lock != $past(core_pll_lock));
	c_rst: cover property ($fell(srst));
endmodule

bind bsc_top bsc_top_checker u_chk (.clk(clk), .srst(srst), .tck(tck),
	.tdo(tdo), .tdo_oe_n(tdo_oe_n), .sdo(sdo), .sdo_oe_n(sdo_oe_n),
	.sdio_oe_n(sdio_oe_n), .sdio_out(sdio_out), .irq_n(irq_n),
	.pll_lock(pll_lock), .core_irq_n(core_irq_n),
	.core_sdo_oe_n(core_sdo_oe_n), .core_pll_lock(core_pll_lock));

// ---- sim/tb.sv ----
// Purpose: self-checking bench for the scan chain
// Assumes: tester model drives the test port
// Notes: chain images rebuilt from pin values
`timescale 1ns/10ps
module tb;
	// ****
	// signals and design
	// ****
	localparam logic [31:0] ID = 32'h5a3c96e1; // arbitrary value
	logic clk, srst, tck, tms, tdi, tdo, tdo_oe_n;
	logic [15:0] pa, pb; // port data pins
	logic da, db, fa, fb, rp, cn, sk, si; // clock, frame, serial pins
	logic co, coe, cs, cse, ci, cl; // core drives
	logic sdio_out, sdio_oe_n, sdo, sdo_oe_n, irq_n, pll_lock;
	logic [63:0] ld, din, o, m;
	logic pre; // sdio held by the preload cell
	int n_mismatch = 0;
	int num_checks = 0;
	int cyc = 0;
	bsc_top #(.IDCODE_VALUE(ID)) u_bsc_top (.clk, .srst, .tck, .tms, .tdi,
		.tdo, .tdo_oe_n, .port_a_data(pa), .port_b_data(pb),
		.port_a_data_clock_in(da), .port_b_data_clock_in(db),
		.port_a_frame_in(fa), .port_b_frame_in(fb), .reset_pin(rp),
		.chip_select_n(cn), .sclk(sk), .sdio_in(si), .sdio_out,
		.sdio_oe_n, .sdo, .sdo_oe_n, .irq_n, .pll_lock,
		.core_sdio_out(co), .core_sdio_oe_n(coe), .core_sdo(cs),
		.core_sdo_oe_n(cse), .core_irq_n(ci), .core_pll_lock(cl));
	bsc_jtag_tester tester (.clk, .tdo, .tck, .tms, .tdi);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// hang guard, the run needs about 4000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 12000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	// ****
	// helpers
	// ****
	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	// new random pin and core values at a falling clk
	task automatic rnd();
		logic [31:0] r;
		r = $urandom;
		@(negedge clk);
		{pa, pb} = $urandom;
		{da, db, fa, fb, rp, cn, sk, si, co, coe, cs, cse, ci, cl} = r[13:0];
	endtask
	// driven pins against the update cells, enables active high
	task automatic pins(input logic [63:0] u);
		chk("pins", u & 64'h3f, {58'h0, sdio_out, irq_n, pll_lock, sdo,
			~sdo_oe_n, ~sdio_oe_n});
	endtask
	// expected unload image; ext gives pin readback of loaded outputs
	function automatic logic [63:0] cap(input bit ext, input logic [63:0] u,
		input logic p);
		logic [63:0] c;
		c = '0;
		c[3:0] = ext ? {u[4], u[4] | u[3], u[3] | u[2], u[2] | u[1]} :
			{ci, cl, cs, ~cse};
		c[8:4] = {rp, cn, sk, si, p};
		for (int i = 0; i < 16; i++) begin
			c[9 + i] = pb[15 - i];
			c[25 + i] = pa[15 - i];
		end
		c[44:41] = {da, fa, db | da, fb | fa};
		return c;
	endfunction
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		srst = 1'b1;
		{pa, pb, da, db, fa, fb, rp, cn, sk, si, co, coe, cs, cse, ci, cl} = '0;
		pre = 1'b0;
		m = '1;
		void'($urandom(6));
		repeat (12) @(negedge clk);
		srst = 1'b0;
		tester.tap_reset();
		tester.scan(0, 32, 64'h0, o);
		chk("idcode", ID, o);
		// bypass, a reserved code, then identification again
		for (int k = 0; k < 3; k++) begin
			tester.scan(1, 5, k == 0 ? 64'h1f : k == 1 ? 64'h0b : 64'h01, o);
			chk("ir_cap", 64'h1, o);
			din = $urandom;
			tester.scan(0, 32, din, o);
			chk("dr", k < 2 ? {din[30:0], 1'b0} : ID, o);
		end
		// sample runs; preload cell unknown on the first
		tester.scan(1, 5, 64'h02, o);
		for (int k = 0; k < 3; k++) begin
			rnd();
			m = k ? '1 : ~64'h10;
			ld = {$urandom, $urandom};
			tester.scan(0, 45, ld, o);
			chk("sample", cap(0, ld, pre) & m, o & m);
			pre = si;
		end
		// serial inputs move after preload, then pin test
		rnd();
		tester.scan(1, 5, 64'h00, o);
		pins(ld);
		din = {$urandom, $urandom};
		tester.scan(0, 45, din, o);
		chk("extest", cap(1, ld, pre), o);
		pins(din);
		// reset in mid-run returns pins to the core
		@(negedge clk);
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		repeat (2) @(negedge clk);
		chk("core", {ci, cl, cs, cse, co, coe},
			{irq_n, pll_lock, sdo, sdo_oe_n, sdio_out, sdio_oe_n});
		tester.tap_reset();
		tester.scan(0, 32, 64'h0, o);
		chk("idcode2", ID, o);
		print_verdict();
	end
endmodule
